// ### rtl/bpx_defs.svh
// Offsets, field positions, reset values and timing counts of the button port block
`ifndef BPX_DEFS_SVH
`define BPX_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BPX_OFS_LATCH 9'h14C
`define BPX_OFS_DIR 9'h14D
`define BPX_OFS_BIRQ 9'h14E
`define BPX_OFS_SPECIAL 9'h15C
`define BPX_OFS_XLOW 9'h15D
`define BPX_OFS_XHIGH 9'h15E
`define BPX_OFS_ISTAT 9'h170
`define BPX_OFS_IMASK 9'h171

// ****************************************
// Button irq control fields
// ****************************************
`define BPX_BIRQ_EN 0
`define BPX_BIRQ_FLAG 1
`define BPX_BIRQ_OCC 2

// ****************************************
// External irq control fields, per source in a pair
// ****************************************
`define BPX_XEN_LO 0
`define BPX_XFLAG_LO 1
`define BPX_XDET_LO 2
`define BPX_XEN_HI 4
`define BPX_XFLAG_HI 5
`define BPX_XDET_HI 6

// ****************************************
// Reset values
// ****************************************
`define BPX_RST_LATCH 8'hFF
`define BPX_RST_DIR 8'h00
`define BPX_RST_CTRL 8'h00
`define BPX_RST_SPECIAL 4'h2

// ****************************************
// Timing counts
// ****************************************
`define BPX_SYNC_STAGES 2

`endif

// ### rtl/bpx_pkg.sv
// Types of the button port block
package bpx_pkg;

    // Detection condition of one external source
    typedef enum logic [1:0] {
        BPX_DET_FALL = 2'b00,
        BPX_DET_LOW = 2'b01,
        BPX_DET_RISE = 2'b10,
        BPX_DET_HIGH = 2'b11
    } bpx_det_t;

endpackage : bpx_pkg

// ### rtl/bpx_sync.sv
// Two-stage synchroniser for a group of input lines
`timescale 1ns/1ns
`default_nettype none

module bpx_sync #(
    parameter int WIDTH = 8,
    parameter logic [7:0] INIT = 8'h00
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    if (WIDTH < 1 || WIDTH > 8)
    begin : g_bad_width
        $error("bpx_sync: WIDTH must be 1 to 8");
    end

    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_reg <= INIT[WIDTH-1:0];
            data_o <= INIT[WIDTH-1:0];
        end
        else
        begin
            meta_reg <= data_i;
            data_o <= meta_reg;
        end
    end

endmodule : bpx_sync

`default_nettype wire

// ### rtl/bpx_xdet.sv
// Condition detector and pending flag for one external interrupt source
`timescale 1ns/1ns
`default_nettype none

module bpx_xdet (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    input wire logic [1:0] det_i,
    input wire logic clear_i,
    output logic pending_o,
    output logic hit_o
);

    logic prev_reg;
    logic hit;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prev_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= level_i;
        end
    end

    always_comb
    begin
        case (bpx_pkg::bpx_det_t'(det_i))
            bpx_pkg::BPX_DET_FALL: hit = prev_reg & ~level_i;
            bpx_pkg::BPX_DET_LOW: hit = ~level_i;
            bpx_pkg::BPX_DET_RISE: hit = ~prev_reg & level_i;
            default: hit = level_i;
        endcase
    end

    assign hit_o = hit;

    // Set wins over clear so no event is lost
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pending_o <= 1'b0;
        end
        else if (hit)
        begin
            pending_o <= 1'b1;
        end
        else if (clear_i)
        begin
            pending_o <= 1'b0;
        end
    end

endmodule : bpx_xdet

`default_nettype wire

// ### rtl/bpx_top.sv
// Button port and special input port with external interrupts
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "bpx_defs.svh"

// Function
// - Eight button inputs read high when released, low when pressed.
// - Button port interrupt is level-sensitive, enabled by its control reg.
// - Special input port is four bits, input only, each an interrupt.
// - Bit 0 high while supply present; feeds external source 0.
// - Bit 1 low while low voltage detected; feeds external source 1.
// - Bit 2 carries ident line 0, normally low; feeds source 2.
// - Bit 3 carries ident line 1, normally low; feeds source 3.
// - Two control registers: sources 0 and 1, then sources 2 and 3.
module bpx_top #(
    parameter int BUTTONS = 8,
    parameter int SOURCES = 4
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] button_n_i,
    output logic [7:0] button_o,
    output logic [7:0] button_oe_o,
    input wire logic supply_present_input_i,
    input wire logic low_voltage_n_input_i,
    input wire logic ident_line_0_input_i,
    input wire logic ident_line_1_input_i,
    output logic [3:0] ext_irq_req_o,
    output logic button_irq_req_o,
    output logic irq_o
);

    if (BUTTONS != 8 || SOURCES != 4)
    begin : g_bad_size
        $error("bpx_top: port widths are fixed at 8 and 4");
    end

    // ****************************************
    // Registers and wires
    // ****************************************
    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic button_en_reg;
    logic button_flag_reg;
    logic button_occ_reg;
    logic [7:0] xlow_reg;
    logic [7:0] xhigh_reg;
    logic [7:0] istat_reg;
    logic [7:0] imask_reg;
    logic [7:0] rdata_next;
    logic [7:0] button_sync;
    logic [3:0] special_raw;
    logic [3:0] special_sync;
    logic [3:0] pending;
    logic [3:0] xhit;
    logic [3:0] xclear;
    logic [3:0] xen;
    logic [7:0] det_bits;
    logic [7:0] pin_view;
    logic button_level;
    logic [7:0] ev_now;
    logic wr_istat;

    function automatic logic hit_addr(input logic [8:0] a,
                                      input logic [8:0] o);
        hit_addr = (a == o);
    endfunction : hit_addr

    // ****************************************
    // Input sampling
    // ****************************************
    // Button pins sampled
    bpx_sync #(.WIDTH(8), .INIT(8'hFF)) u_button_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .data_i(button_n_i),
        .data_o(button_sync)
    );

    assign special_raw = {ident_line_1_input_i, ident_line_0_input_i,
                          low_voltage_n_input_i, supply_present_input_i};

    bpx_sync #(.WIDTH(4), .INIT({4'h0, `BPX_RST_SPECIAL})) u_special_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .data_i(special_raw),
        .data_o(special_sync)
    );

    // ****************************************
    // External interrupt sources
    // ****************************************
    // Low pair and high pair control fields
    assign det_bits = {xhigh_reg[`BPX_XDET_HI+1:`BPX_XDET_HI],
                       xhigh_reg[`BPX_XDET_LO+1:`BPX_XDET_LO],
                       xlow_reg[`BPX_XDET_HI+1:`BPX_XDET_HI],
                       xlow_reg[`BPX_XDET_LO+1:`BPX_XDET_LO]};
    assign xen = {xhigh_reg[`BPX_XEN_HI], xhigh_reg[`BPX_XEN_LO],
                  xlow_reg[`BPX_XEN_HI], xlow_reg[`BPX_XEN_LO]};

    // Writing zero to a flag bit clears it
    assign xclear[0] = wr_i && hit_addr(addr_i, `BPX_OFS_XLOW)
                       && !wdata_i[`BPX_XFLAG_LO];
    assign xclear[1] = wr_i && hit_addr(addr_i, `BPX_OFS_XLOW)
                       && !wdata_i[`BPX_XFLAG_HI];
    assign xclear[2] = wr_i && hit_addr(addr_i, `BPX_OFS_XHIGH)
                       && !wdata_i[`BPX_XFLAG_LO];
    assign xclear[3] = wr_i && hit_addr(addr_i, `BPX_OFS_XHIGH)
                       && !wdata_i[`BPX_XFLAG_HI];

    // Each port bit feeds its source
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_src
            bpx_xdet u_det (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .level_i(special_sync[gi]),
                .det_i(det_bits[2*gi+1:2*gi]),
                .clear_i(xclear[gi]),
                .pending_o(pending[gi]),
                .hit_o(xhit[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ext_irq_req_o <= 4'h0;
        end
        else
        begin
            ext_irq_req_o <= pending & xen;
        end
    end

    // ****************************************
    // Button port
    // ****************************************
    // Per-bit direction, driven pins show the latch
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pin_view[i] = dir_reg[i] ? latch_reg[i] : button_sync[i];
        end
    end

    // Level condition: any input button held low
    assign button_level = |(~button_sync & ~dir_reg);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            latch_reg <= `BPX_RST_LATCH;
            dir_reg <= `BPX_RST_DIR;
        end
        else if (wr_i && hit_addr(addr_i, `BPX_OFS_LATCH))
        begin
            latch_reg <= wdata_i;
        end
        else if (wr_i && hit_addr(addr_i, `BPX_OFS_DIR))
        begin
            dir_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            button_o <= `BPX_RST_LATCH;
            button_oe_o <= `BPX_RST_DIR;
        end
        else
        begin
            button_o <= latch_reg;
            button_oe_o <= dir_reg;
        end
    end

    // Flag sets while the level holds and clears only on a zero write after it drops, so a held button keeps asking
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            button_en_reg <= 1'b0;
            button_occ_reg <= 1'b0;
            button_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_i && hit_addr(addr_i, `BPX_OFS_BIRQ))
            begin
                button_en_reg <= wdata_i[`BPX_BIRQ_EN];
                button_occ_reg <= wdata_i[`BPX_BIRQ_OCC];
            end
            if (button_occ_reg && button_level)
            begin
                button_flag_reg <= 1'b1;
            end
            else if (wr_i && hit_addr(addr_i, `BPX_OFS_BIRQ)
                     && !wdata_i[`BPX_BIRQ_FLAG])
            begin
                button_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            button_irq_req_o <= 1'b0;
        end
        else
        begin
            button_irq_req_o <= button_flag_reg & button_en_reg;
        end
    end

    // ****************************************
    // Control registers of the source pairs
    // ****************************************
    // Flag bits are owned by the detectors
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            xlow_reg <= `BPX_RST_CTRL;
            xhigh_reg <= `BPX_RST_CTRL;
        end
        else if (wr_i && hit_addr(addr_i, `BPX_OFS_XLOW))
        begin
            xlow_reg <= wdata_i;
        end
        else if (wr_i && hit_addr(addr_i, `BPX_OFS_XHIGH))
        begin
            xhigh_reg <= wdata_i;
        end
    end

    // ****************************************
    // Sticky status, mask and interrupt line
    // ****************************************
    assign ev_now = {3'b000, button_occ_reg & button_level, xhit};
    assign wr_istat = wr_i && hit_addr(addr_i, `BPX_OFS_ISTAT);

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            istat_reg <= 8'h00;
        end
        else
        begin
            istat_reg <= ev_now | (istat_reg & ~(wr_istat ? wdata_i : 8'h00));
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            imask_reg <= 8'h00;
        end
        else if (wr_i && hit_addr(addr_i, `BPX_OFS_IMASK))
        begin
            imask_reg <= wdata_i & 8'h1F;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(istat_reg & imask_reg);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb
    begin
        if (hit_addr(addr_i, `BPX_OFS_LATCH))
        begin
            // Released reads one, pressed reads zero
            rdata_next = pin_view;
        end
        else if (hit_addr(addr_i, `BPX_OFS_DIR))
        begin
            rdata_next = dir_reg;
        end
        else if (hit_addr(addr_i, `BPX_OFS_BIRQ))
        begin
            rdata_next = {5'h00, button_occ_reg, button_flag_reg,
                          button_en_reg};
        end
        else if (hit_addr(addr_i, `BPX_OFS_SPECIAL))
        begin
            rdata_next = {4'h0, special_sync};
        end
        else if (hit_addr(addr_i, `BPX_OFS_XLOW))
        begin
            rdata_next = {xlow_reg[7:6], pending[1], xlow_reg[4:2],
                          pending[0], xlow_reg[0]};
        end
        else if (hit_addr(addr_i, `BPX_OFS_XHIGH))
        begin
            rdata_next = {xhigh_reg[7:6], pending[3], xhigh_reg[4:2],
                          pending[2], xhigh_reg[0]};
        end
        else if (hit_addr(addr_i, `BPX_OFS_ISTAT))
        begin
            rdata_next = istat_reg;
        end
        else if (hit_addr(addr_i, `BPX_OFS_IMASK))
        begin
            rdata_next = imask_reg;
        end
        else
        begin
            // Unmapped reads zero
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            rdata_o <= rdata_next;
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

endmodule : bpx_top

`default_nettype wire

// ### tb/bpx_top_chk.sv
// Port-level assertions of the button port block
`timescale 1ns/1ns
`default_nettype none
`include "bpx_defs.svh"

module bpx_top_chk (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] button_o,
    input wire logic [7:0] button_oe_o,
    input wire logic [3:0] ext_irq_req_o,
    input wire logic button_irq_req_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ****************************************
    // Register side
    // ****************************************
    read_idle_zero_a: assert property (
        !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    unmapped_read_a: assert property (
        rd_i && addr_i == 9'h000 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    special_width_a: assert property (
        rd_i && addr_i == `BPX_OFS_SPECIAL |=> rdata_o[7:4] == 4'h0)
        else $error("special port upper bits set");
    // Output copy lags the register by one cycle
    dir_copy_a: assert property (
        (wr_i && addr_i == `BPX_OFS_DIR) ##1 !wr_i
        |=> button_oe_o == $past(wdata_i, 2)) else $error("direction lost");
    latch_copy_a: assert property (
        (wr_i && addr_i == `BPX_OFS_LATCH) ##1 !wr_i
        |=> button_o == $past(wdata_i, 2)) else $error("latch lost");

    // ****************************************
    // Interrupt side
    // ****************************************
    xlow_enable_a: assert property (
        (wr_i && addr_i == `BPX_OFS_XLOW && !wdata_i[0]) ##1 !wr_i
        |=> !ext_irq_req_o[0]) else $error("source 0 request while off");
    xhigh_enable_a: assert property (
        (wr_i && addr_i == `BPX_OFS_XHIGH && !wdata_i[4]) ##1 !wr_i
        |=> !ext_irq_req_o[3]) else $error("source 3 request while off");
    mask_gate_a: assert property (
        (wr_i && addr_i == `BPX_OFS_IMASK && wdata_i[4:0] == 5'h00)
        ##1 !wr_i |=> !irq_o) else $error("irq while all masked");
    button_enable_a: assert property (
        (wr_i && addr_i == `BPX_OFS_BIRQ && !wdata_i[0]) ##1 !wr_i
        |=> !button_irq_req_o) else $error("button request while off");
endmodule : bpx_top_chk

bind bpx_top bpx_top_chk u_chk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .button_o(button_o),
    .button_oe_o(button_oe_o),
    .ext_irq_req_o(ext_irq_req_o),
    .button_irq_req_o(button_irq_req_o),
    .irq_o(irq_o)
);
`default_nettype wire

// ### tb/bpx_pins_model.sv
// Buttons and special signal lines facing the port pins
`timescale 1ns/1ns
`default_nettype none

module bpx_pins_model (
    input wire logic [7:0] press_i,
    input wire logic [3:0] line_i,
    input wire logic [7:0] button_o_i,
    input wire logic [7:0] button_oe_i,
    output logic [7:0] button_n_o,
    output logic [3:0] line_o
);
    // pull-up, pressed low
    // Pins set as outputs show the driven level, not the button
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            button_n_o[i] = button_oe_i[i] ? button_o_i[i] : !press_i[i];
        end
    end
    assign line_o = line_i;
endmodule : bpx_pins_model
`default_nettype wire

// ### tb/bpx_top_tb_top.sv
// Register-level bench of the button port block
`timescale 1ns/1ns
`default_nettype none
`include "bpx_defs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    errors++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module bpx_top_tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] press = 8'h00;
    logic [3:0] line = 4'h2;
    logic [7:0] rdata_o;
    logic [7:0] button_o;
    logic [7:0] button_oe_o;
    logic [7:0] pins_n;
    logic [3:0] lines;
    logic [3:0] ext_irq_req_o;
    logic button_irq_req_o;
    logic irq_o;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    bpx_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o),
        .button_n_i(pins_n), .button_o(button_o), .button_oe_o(button_oe_o),
        .supply_present_input_i(lines[0]), .low_voltage_n_input_i(lines[1]),
        .ident_line_0_input_i(lines[2]), .ident_line_1_input_i(lines[3]),
        .ext_irq_req_o(ext_irq_req_o), .button_irq_req_o(button_irq_req_o),
        .irq_o(irq_o));
    bpx_pins_model u_pins (.press_i(press), .line_i(line),
        .button_o_i(button_o), .button_oe_i(button_oe_o),
        .button_n_o(pins_n), .line_o(lines));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Hang guard, far above the two hundred or so cycles needed
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic set_pins(input logic [7:0] p, input logic [3:0] l);
        @(posedge clk_i);
        press <= p;
        line <= l;
    endtask : set_pins
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rdata_o, exp)
    endtask : rd_chk

    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        tick(2);
        rd_chk(`BPX_OFS_LATCH, 8'hFF);
        rd_chk(`BPX_OFS_DIR, 8'h00);
        rd_chk(`BPX_OFS_BIRQ, 8'h00);
        rd_chk(`BPX_OFS_XLOW, 8'h00);
        rd_chk(`BPX_OFS_XHIGH, 8'h00);
        rd_chk(9'h000, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            set_pins(8'h00, 4'h2 ^ (4'h1 << i));
            tick(4);
            rd_chk(`BPX_OFS_SPECIAL, {4'h0, line});
        end
        set_pins(8'h00, 4'h2);
        tick(5);
        wr_reg(`BPX_OFS_ISTAT, 8'hFF);
        wr_reg(`BPX_OFS_XLOW, 8'h09);
        wr_reg(`BPX_OFS_IMASK, 8'h01);
        tick(3);
        `CHK(irq_o, 1'b0)
        set_pins(8'h00, 4'h3);
        tick(6);
        `CHK(ext_irq_req_o[0], 1'b1)
        `CHK(irq_o, 1'b1)
        rd_chk(`BPX_OFS_XLOW, 8'h0B);
        rd_chk(`BPX_OFS_ISTAT, 8'h01);
        wr_reg(`BPX_OFS_IMASK, 8'h00);
        tick(3);
        `CHK(irq_o, 1'b0)
        wr_reg(`BPX_OFS_IMASK, 8'h01);
        tick(3);
        `CHK(irq_o, 1'b1)
        wr_reg(`BPX_OFS_ISTAT, 8'h01);
        tick(3);
        `CHK(irq_o, 1'b0)
        `CHK(ext_irq_req_o[0], 1'b1)
        wr_reg(`BPX_OFS_XLOW, 8'h09);
        tick(3);
        `CHK(ext_irq_req_o[0], 1'b0)
        wr_reg(`BPX_OFS_XLOW, 8'h08);
        set_pins(8'h00, 4'h2);
        set_pins(8'h00, 4'h3);
        tick(6);
        `CHK(ext_irq_req_o[0], 1'b0)
        rd_chk(`BPX_OFS_XLOW, 8'h0A);
        wr_reg(`BPX_OFS_XHIGH, 8'hDD);
        set_pins(8'h00, 4'hE);
        tick(6);
        `CHK(ext_irq_req_o[3:2], 2'b11)
        wr_reg(`BPX_OFS_XHIGH, 8'h0D);
        tick(3);
        `CHK(ext_irq_req_o[3:2], 2'b01)
        set_pins(8'h08, 4'h2);
        tick(4);
        rd_chk(`BPX_OFS_LATCH, 8'hF7);
        wr_reg(`BPX_OFS_DIR, 8'h0F);
        wr_reg(`BPX_OFS_LATCH, 8'hA5);
        tick(4);
        `CHK(button_oe_o, 8'h0F)
        `CHK(button_o, 8'hA5)
        rd_chk(`BPX_OFS_LATCH, 8'hF5);
        wr_reg(`BPX_OFS_DIR, 8'h00);
        set_pins(8'h01, 4'h2);
        wr_reg(`BPX_OFS_BIRQ, 8'h05);
        tick(6);
        `CHK(button_irq_req_o, 1'b1)
        wr_reg(`BPX_OFS_BIRQ, 8'h05);
        tick(4);
        `CHK(button_irq_req_o, 1'b1)
        set_pins(8'h00, 4'h2);
        tick(4);
        wr_reg(`BPX_OFS_BIRQ, 8'h05);
        tick(4);
        `CHK(button_irq_req_o, 1'b0)
        wr_reg(`BPX_OFS_BIRQ, 8'h04);
        tick(3);
        // Low level on source 0, falling edge on source 1
        wr_reg(`BPX_OFS_XLOW, 8'h15);
        tick(3);
        `CHK(ext_irq_req_o[1:0], 2'b01)
        set_pins(8'h00, 4'h0);
        tick(6);
        `CHK(ext_irq_req_o[1:0], 2'b11)
        finish_test();
    end
endmodule : bpx_top_tb_top
`default_nettype wire
